// ==== link_ext_defines.vh ====
// Notes on behaviour
// - Context 0 frame sync holds off storing until a frame-start tag, branch control 01b.
// - Out-of-place frame-start tag makes context 0 jump to the frame resync pointer.
// - Frame sync acts only with header strip set and header keeping off.
// - Header strip with header keeping off drops first two payload quadlets per packet.
// - Video register bits 3 and 2 always read as zero.
// - Link register seen through set, clear and config alias; one storage.
// - Link register resets to zero on host or power reset.
// - Link register bits 31-16 read as zero.
// - Bit 15 set stops out-of-order async transmit pipelining.
// - Threshold code 00 2K, 01 1.7K, 10 1K, 11 512 bytes.
// - Programmed threshold holds only until first underrun; then store-and-forward.
// - A retried async packet uses the 2K store-and-forward threshold.
// - Below 2K, start at threshold or when whole packet loaded, whichever first.
// - FIFO empty mid-packet sends it errored and forces store-and-forward.
// - Frame start is third quadlet first bytes 1Fh then X7h.
`ifndef LINK_EXT_DEFINES_VH
`define LINK_EXT_DEFINES_VH

`define VID_SET_OFS      12'hA80
`define VID_CLR_OFS      12'hA84
`define LINK_SET_OFS     12'hA88
`define LINK_CLR_OFS     12'hA8C
`define LINK_CFG_OFS     8'hF4

`define VID_RESET        32'h00000000
`define VID_WMASK        32'h00000003
`define LINK_RESET       32'h00000000
`define LINK_WMASK       32'h0000F000

`define BIT_STRIP0       0
`define BIT_SYNC0        1
`define BIT_PIPE_OFF     15
`define BIT_RSVD14       14
`define THR_LSB          12
`define THR_MSB          13

`define THR_2K           12'h800
`define THR_1K7          12'h6CC
`define THR_1K           12'h400
`define THR_512          12'h200

`define TAG_BYTE0        8'h1F
`define TAG_NIBBLE1      4'h7
`define BRANCH_FILL      2'h1

`endif

// ==== rx_ctx0_filter.v ====
`timescale 1ns/10ps
`include "link_ext_defines.vh"

module rx_ctx0_filter
(
  input  wire        clock,
  input  wire        rst_b,
  input  wire        stripEn,
  input  wire        syncEn,
  input  wire        keepRxHeader,
  input  wire        bufferFillMode,
  input  wire [1:0]  branchCtl,
  input  wire        atFrameBoundary,
  input  wire        quadValid,
  input  wire        quadFirst,
  input  wire [31:0] quadData,
  output reg         storeValid,
  output reg  [31:0] storeData,
  output reg         frameJump,
  output reg         waitingFrame
);

  reg  [1:0] quadIndex_reg;
  reg        syncActive_reg;
  wire [1:0] curIndex;
  wire       stripActive;
  wire       syncActive;
  wire       tagSeen;
  wire       dropHeader;

  // ****************************************************************
  // Qualification
  // ****************************************************************
  assign stripActive = stripEn & ~keepRxHeader;
  assign syncActive  = syncEn & stripActive & bufferFillMode &
                       (branchCtl == `BRANCH_FILL);
  assign curIndex    = quadFirst ? 2'h0 : quadIndex_reg;
  assign tagSeen     = quadValid & (curIndex == 2'h2) &
                       (quadData[31:24] == `TAG_BYTE0) &
                       (quadData[19:16] == `TAG_NIBBLE1);
  assign dropHeader  = stripActive & (curIndex < 2'h2);

  // ****************************************************************
  // Quadlet path
  // ****************************************************************
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      quadIndex_reg  <= 2'h0;
      syncActive_reg <= 1'b0;
      waitingFrame   <= 1'b0;
      storeValid     <= 1'b0;
      storeData      <= 32'h00000000;
      frameJump      <= 1'b0;
    end
    else
    begin
      syncActive_reg <= syncActive;
      frameJump      <= 1'b0;
      storeValid     <= 1'b0;
      if (quadValid && curIndex != 2'h3)
        quadIndex_reg <= curIndex + 2'h1;
      else if (quadValid)
        quadIndex_reg <= 2'h3;
      // Arm on enabling so a stream caught mid-frame is skipped
      if (!syncActive)
        waitingFrame <= 1'b0;
      else if (!syncActive_reg)
        waitingFrame <= 1'b1;
      else if (waitingFrame && tagSeen)
        waitingFrame <= 1'b0;
      if (syncActive && syncActive_reg && !waitingFrame &&
          tagSeen && !atFrameBoundary)
        frameJump <= 1'b1;
      if (quadValid && !dropHeader)
      begin
        if (!(syncActive && (!syncActive_reg ||
              (waitingFrame && !tagSeen))))
        begin
          storeValid <= 1'b1;
          storeData  <= quadData;
        end
      end
    end
  end

endmodule // rx_ctx0_filter

// ==== link_extension_control_regs.v ====
`timescale 1ns/10ps
`include "link_ext_defines.vh"

module link_extension_control_regs
(
  input  wire        clock,
  input  wire        rst_b,
  input  wire        powerRst_b,
  // Host memory-space register port
  input  wire [11:0] regAddr,
  input  wire        regWrite,
  input  wire        regRead,
  input  wire [31:0] regWrData,
  output reg  [31:0] regRdData,
  output reg         regRdValid,
  // Configuration-space alias port
  input  wire [7:0]  cfgAddr,
  input  wire        cfgWrite,
  input  wire        cfgRead,
  input  wire [31:0] cfgWrData,
  output reg  [31:0] cfgRdData,
  output reg         cfgRdValid,
  // Async transmit queue side
  input  wire        txPktPending,
  input  wire [11:0] txFifoBytes,
  input  wire        txPktLoaded,
  input  wire        txRetry,
  input  wire        txFifoEmpty,
  input  wire        txPktDone,
  output reg         txStart,
  output reg         txErrored,
  output reg         storeFwdActive,
  output reg         asyncTxPipelineOff,
  output reg         rsvd14Out,
  // Receive context 0 side
  input  wire        keepRxHeader,
  input  wire        bufferFillMode,
  input  wire [1:0]  branchCtl,
  input  wire        atFrameBoundary,
  input  wire        rxQuadValid,
  input  wire        rxQuadFirst,
  input  wire [31:0] rxQuadData,
  output wire        rxStoreValid,
  output wire [31:0] rxStoreData,
  output wire        frameResyncJump,
  output wire        rxWaitingFrame
);

  // ****************************************************************
  // Reset
  // ****************************************************************
  // Either the host fundamental reset or the power reset clears the
  // block; both are asynchronous and active low.
  wire anyRst_b;

  assign anyRst_b = rst_b & powerRst_b;

  // ****************************************************************
  // Register storage
  // ****************************************************************
  reg  [31:0] linkEnh_reg;
  reg  [31:0] linkEnh_next;
  reg  [31:0] vidEnh_reg;
  reg  [31:0] vidEnh_next;
  wire        wrVidSet;
  wire        wrVidClr;
  wire        wrLinkSet;
  wire        wrLinkClr;
  wire        wrLinkCfg;
  wire [31:0] linkView;
  wire [31:0] vidView;

  assign wrVidSet  = regWrite & (regAddr == `VID_SET_OFS);
  assign wrVidClr  = regWrite & (regAddr == `VID_CLR_OFS);
  assign wrLinkSet = regWrite & (regAddr == `LINK_SET_OFS);
  assign wrLinkClr = regWrite & (regAddr == `LINK_CLR_OFS);
  assign wrLinkCfg = cfgWrite & (cfgAddr == `LINK_CFG_OFS);

  // Reserved bits are masked on read as well as write
  assign linkView = linkEnh_reg & `LINK_WMASK;
  assign vidView  = vidEnh_reg & `VID_WMASK;

  // Clear first, then set, so a set in the same cycle wins.
  // A config write replaces the bits before either is applied.
  always @*
  begin
    linkEnh_next = linkEnh_reg;
    if (wrLinkCfg)
      linkEnh_next = cfgWrData & `LINK_WMASK;
    if (wrLinkClr)
      linkEnh_next = linkEnh_next & ~(regWrData & `LINK_WMASK);
    if (wrLinkSet)
      linkEnh_next = linkEnh_next | (regWrData & `LINK_WMASK);
  end

  always @*
  begin
    vidEnh_next = vidEnh_reg;
    if (wrVidClr)
      vidEnh_next = vidEnh_next & ~(regWrData & `VID_WMASK);
    if (wrVidSet)
      vidEnh_next = vidEnh_next | (regWrData & `VID_WMASK);
  end

  always @(posedge clock or negedge anyRst_b)
  begin
    if (!anyRst_b)
    begin
      linkEnh_reg <= `LINK_RESET;
      vidEnh_reg  <= `VID_RESET;
    end
    else
    begin
      linkEnh_reg <= linkEnh_next;
      vidEnh_reg  <= vidEnh_next;
    end
  end

  // ****************************************************************
  // Read ports
  // ****************************************************************
  // One cycle of read latency; unmapped offsets read as zero.
  always @(posedge clock or negedge anyRst_b)
  begin
    if (!anyRst_b)
    begin
      regRdData  <= 32'h00000000;
      regRdValid <= 1'b0;
      cfgRdData  <= 32'h00000000;
      cfgRdValid <= 1'b0;
    end
    else
    begin
      regRdValid <= regRead;
      cfgRdValid <= cfgRead;
      if (regRead)
      begin
        case (regAddr)
          `VID_SET_OFS,
          `VID_CLR_OFS:  regRdData <= vidView;
          `LINK_SET_OFS,
          `LINK_CLR_OFS: regRdData <= linkView;
          default:       regRdData <= 32'h00000000;
        endcase
      end
      if (cfgRead)
      begin
        if (cfgAddr == `LINK_CFG_OFS)
          cfgRdData <= linkView;
        else
          cfgRdData <= 32'h00000000;
      end
    end
  end

  // ****************************************************************
  // Control outputs
  // ****************************************************************
  // Software is expected to load these before link power goes on;
  // nothing here blocks a later change.
  always @(posedge clock or negedge anyRst_b)
  begin
    if (!anyRst_b)
    begin
      asyncTxPipelineOff <= 1'b0;
      rsvd14Out          <= 1'b0;
    end
    else
    begin
      asyncTxPipelineOff <= linkEnh_reg[`BIT_PIPE_OFF];
      // Passed on untouched; only zero is a supported value
      rsvd14Out          <= linkEnh_reg[`BIT_RSVD14];
    end
  end

  // ****************************************************************
  // Async transmit threshold
  // ****************************************************************
  localparam TX_IDLE = 2'h0;
  localparam TX_WAIT = 2'h1;
  localparam TX_SEND = 2'h2;

  reg  [1:0]  txState_reg;
  reg  [1:0]  txState_next;
  reg         sfLatched_reg;
  reg  [11:0] thrBytes;
  reg         startNow;
  reg         underrun;
  reg         retryHeld_reg;
  wire        fullOnly;

  always @*
  begin
    case (linkEnh_reg[`THR_MSB:`THR_LSB])
      2'h0:    thrBytes = `THR_2K;
      2'h1:    thrBytes = `THR_1K7;
      2'h2:    thrBytes = `THR_1K;
      2'h3:    thrBytes = `THR_512;
      default: thrBytes = `THR_2K;
    endcase
  end

  // Store-and-forward waits for the whole packet regardless of level
  assign fullOnly = sfLatched_reg |
                    retryHeld_reg |
                    (linkEnh_reg[`THR_MSB:`THR_LSB] == 2'h0);

  always @*
  begin
    txState_next = txState_reg;
    startNow     = 1'b0;
    underrun     = 1'b0;
    case (txState_reg)
      TX_IDLE:
      begin
        if (txPktPending)
          txState_next = TX_WAIT;
      end
      TX_WAIT:
      begin
        if (txPktLoaded ||
            (!fullOnly && txFifoBytes >= thrBytes))
        begin
          startNow     = 1'b1;
          txState_next = TX_SEND;
        end
      end
      TX_SEND:
      begin
        if (txPktDone)
          txState_next = TX_IDLE;
        else if (txFifoEmpty && !txPktLoaded)
        begin
          underrun     = 1'b1;
          txState_next = TX_IDLE;
        end
      end
      default:
        txState_next = TX_IDLE;
    endcase
  end

  always @(posedge clock or negedge anyRst_b)
  begin
    if (!anyRst_b)
    begin
      txState_reg    <= TX_IDLE;
      sfLatched_reg  <= 1'b0;
      retryHeld_reg  <= 1'b0;
      txStart        <= 1'b0;
      txErrored      <= 1'b0;
      storeFwdActive <= 1'b0;
    end
    else
    begin
      txState_reg <= txState_next;
      txStart     <= startNow;
      txErrored   <= underrun;
      // Sticky until reset: a host that underran once stays safe
      if (underrun)
        sfLatched_reg <= 1'b1;
      if (txState_reg == TX_IDLE && txPktPending)
        retryHeld_reg <= txRetry;
      storeFwdActive <= sfLatched_reg | underrun;
    end
  end

  // ****************************************************************
  // Receive context 0
  // ****************************************************************
  rx_ctx0_filter rxFilter
  (
    .clock           (clock),
    .rst_b           (anyRst_b),
    .stripEn         (vidEnh_reg[`BIT_STRIP0]),
    .syncEn          (vidEnh_reg[`BIT_SYNC0]),
    .keepRxHeader    (keepRxHeader),
    .bufferFillMode  (bufferFillMode),
    .branchCtl       (branchCtl),
    .atFrameBoundary (atFrameBoundary),
    .quadValid       (rxQuadValid),
    .quadFirst       (rxQuadFirst),
    .quadData        (rxQuadData),
    .storeValid      (rxStoreValid),
    .storeData       (rxStoreData),
    .frameJump       (frameResyncJump),
    .waitingFrame    (rxWaitingFrame)
  );

endmodule // link_extension_control_regs

// ==== link_extension_control_regs_checker.sv ====
`timescale 1ns/10ps
`include "link_ext_defines.vh"

module link_ext_checker
(
  input wire        clock,
  input wire        rst_b,
  input wire        powerRst_b,
  input wire [11:0] regAddr,
  input wire        regWrite,
  input wire        regRead,
  input wire [31:0] regWrData,
  input wire [31:0] regRdData,
  input wire        regRdValid,
  input wire [31:0] cfgRdData,
  input wire        cfgRdValid,
  input wire [11:0] txFifoBytes,
  input wire        txPktLoaded,
  input wire        txStart,
  input wire        txErrored,
  input wire        storeFwdActive,
  input wire        asyncTxPipelineOff
);
  default clocking cb @(posedge clock); endclocking
  // Either reset clears everything, so both silence the checks
  default disable iff (!rst_b || !powerRst_b);
  //****************************************
  // Register views
  //****************************************
  property p_rd_valid; regRead |=> regRdValid; endproperty
  a_rd_valid: assert property (p_rd_valid)
    else $error("read strobe gave no valid");
  property p_rsvd_hi; regRdValid |-> regRdData[31:16] == 16'h0000; endproperty
  a_rsvd_hi: assert property (p_rsvd_hi)
    else $error("reserved upper bits not zero");
  property p_cfg_rsvd;
    cfgRdValid |-> cfgRdData[31:16] == 16'h0000 && cfgRdData[11:0] == 12'h000;
  endproperty
  a_cfg_rsvd: assert property (p_cfg_rsvd)
    else $error("config alias reserved bits not zero");
  property p_vid_rsvd;
    regRdValid && ($past(regAddr) == `VID_SET_OFS
      || $past(regAddr) == `VID_CLR_OFS) |-> regRdData[31:2] == 30'h0;
  endproperty
  a_vid_rsvd: assert property (p_vid_rsvd)
    else $error("video reserved bits not zero");
  property p_set15;
    regWrite && regAddr == `LINK_SET_OFS && regWrData[15]
      |-> ##2 asyncTxPipelineOff;
  endproperty
  a_set15: assert property (p_set15)
    else $error("set of bit 15 did not disable pipelining");
  property p_clr15;
    regWrite && regAddr == `LINK_CLR_OFS && regWrData[15]
      |-> ##2 !asyncTxPipelineOff;
  endproperty
  a_clr15: assert property (p_clr15)
    else $error("clear of bit 15 did not take");
  //****************************************
  // Transmit threshold
  //****************************************
  property p_err_sf; txErrored |-> storeFwdActive; endproperty
  a_err_sf: assert property (p_err_sf)
    else $error("underrun without store and forward");
  property p_sticky; storeFwdActive |=> storeFwdActive; endproperty
  a_sticky: assert property (p_sticky)
    else $error("store and forward dropped");
  property p_start;
    txStart |-> $past(txPktLoaded) || $past(txFifoBytes) >= `THR_512;
  endproperty
  a_start: assert property (p_start)
    else $error("start below every threshold");
  c_err: cover property (txErrored);
  c_start: cover property (txStart);
  c_cfg: cover property (cfgRdValid && cfgRdData[15]);
endmodule // link_ext_checker

bind link_extension_control_regs link_ext_checker i_chk
(
  .clock(clock), .rst_b(rst_b), .powerRst_b(powerRst_b),
  .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
  .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
  .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid),
  .txFifoBytes(txFifoBytes), .txPktLoaded(txPktLoaded), .txStart(txStart),
  .txErrored(txErrored), .storeFwdActive(storeFwdActive),
  .asyncTxPipelineOff(asyncTxPipelineOff)
);

// ==== link_extension_control_regs_tb_top.sv ====
`timescale 1ns/10ps
`include "link_ext_defines.vh"

module link_extension_control_regs_tb_top;
  logic clock = 0, rst_b = 0, powerRst_b = 1;
  logic [11:0] regAddr = 0, txFifoBytes = 0;
  logic [7:0] cfgAddr = 0;
  logic [31:0] regWrData = 0, cfgWrData = 0, rxQuadData = 0;
  logic regWrite = 0, regRead = 0, cfgWrite = 0, cfgRead = 0;
  logic txPktPending = 0, txPktLoaded = 0, txRetry = 0, txFifoEmpty = 0;
  logic txPktDone = 0, keepRxHeader = 0, bufferFillMode = 1;
  logic atFrameBoundary = 1, rxQuadValid = 0, rxQuadFirst = 0;
  logic [1:0] branchCtl = 2'h1;
  wire [31:0] regRdData, cfgRdData, rxStoreData;
  wire regRdValid, cfgRdValid, txStart, txErrored, storeFwdActive;
  wire asyncTxPipelineOff, rsvd14Out, rxStoreValid, frameResyncJump;
  wire rxWaitingFrame;
  int errors = 0, num_checks = 0, seed = 10392;
  int linkM = 0, vidM = 0, waitM = 0, startCnt = 0, errCnt = 0;
  int jmpCnt = 0, jmpE = 0, k;
  logic [31:0] gotQ[$], expQ[$];
  logic [11:0] tbl[5] = '{`VID_SET_OFS, `VID_CLR_OFS, `LINK_SET_OFS,
                          `LINK_CLR_OFS, `LINK_CFG_OFS};

  link_extension_control_regs i_dut
  (
    .clock(clock), .rst_b(rst_b), .powerRst_b(powerRst_b),
    .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
    .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
    .cfgAddr(cfgAddr), .cfgWrite(cfgWrite), .cfgRead(cfgRead),
    .cfgWrData(cfgWrData), .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid),
    .txPktPending(txPktPending), .txFifoBytes(txFifoBytes),
    .txPktLoaded(txPktLoaded), .txRetry(txRetry), .txFifoEmpty(txFifoEmpty),
    .txPktDone(txPktDone), .txStart(txStart), .txErrored(txErrored),
    .storeFwdActive(storeFwdActive), .asyncTxPipelineOff(asyncTxPipelineOff),
    .rsvd14Out(rsvd14Out), .keepRxHeader(keepRxHeader),
    .bufferFillMode(bufferFillMode), .branchCtl(branchCtl),
    .atFrameBoundary(atFrameBoundary), .rxQuadValid(rxQuadValid),
    .rxQuadFirst(rxQuadFirst), .rxQuadData(rxQuadData),
    .rxStoreValid(rxStoreValid), .rxStoreData(rxStoreData),
    .frameResyncJump(frameResyncJump), .rxWaitingFrame(rxWaitingFrame)
  );

  always #10 clock = ~clock;
  //****************************************
  // Output monitors
  //****************************************
  always @(posedge clock)
  begin
    if (rxStoreValid === 1'b1) gotQ.push_back(rxStoreData);
    if (txStart === 1'b1) startCnt++;
    if (txErrored === 1'b1) errCnt++;
    if (frameResyncJump === 1'b1) jmpCnt++;
  end

  task complete_run;
    $display("Checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk32(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) errors++;
    if (g !== e) $display("ERROR %s expected %h got %h", n, e, g);
  endtask
  task chk1(input string n, input logic e, input logic g);
    chk32(n, {31'h0, e}, {31'h0, g});
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  //****************************************
  // Register bus tasks and model
  //****************************************
  task wr(input logic c, input logic [11:0] a, input logic [31:0] d);
    if (c) {cfgWrite, cfgAddr, cfgWrData} = {1'b1, a[7:0], d};
    else {regWrite, regAddr, regWrData} = {1'b1, a, d};
    if (c && a == `LINK_CFG_OFS)
      linkM = (linkM & ~`LINK_WMASK) | (d & `LINK_WMASK);
    else if (!c && a == `VID_SET_OFS) vidM |= d & `VID_WMASK;
    else if (!c && a == `VID_CLR_OFS) vidM &= ~(d & `VID_WMASK);
    else if (!c && a == `LINK_SET_OFS) linkM |= d & `LINK_WMASK;
    else if (!c && a == `LINK_CLR_OFS) linkM &= ~(d & `LINK_WMASK);
    cyc(1);
    {regWrite, cfgWrite} = 2'b00;
    cyc(1);
  endtask
  task rd(input logic c, input logic [11:0] a, input logic [31:0] e);
    if (c) {cfgRead, cfgAddr} = {1'b1, a[7:0]};
    else {regRead, regAddr} = {1'b1, a};
    cyc(1);
    {regRead, cfgRead} = 2'b00;
    chk1("read valid", 1'b1, c ? cfgRdValid : regRdValid);
    chk32("read data", e, c ? cfgRdData : regRdData);
    cyc(1);
  endtask
  task check_all;
    for (int i = 0; i < 5; i++)
      rd(i == 4, tbl[i], i < 2 ? vidM : linkM);
    chk1("pipeline off", linkM[15], asyncTxPipelineOff);
    chk1("bit 14 copy", linkM[14], rsvd14Out);
  endtask
  //****************************************
  // Transmit and receive tasks
  //****************************************
  task tx(input logic [11:0] pre, thr, input logic ld, rt);
    int s;
    s = startCnt;
    {txPktPending, txRetry, txFifoBytes} = {1'b1, rt, pre};
    cyc(4);
    chk32("early start", s, startCnt);
    if (ld) txPktLoaded = 1;
    else txFifoBytes = thr;
    cyc(3);
    chk32("start", s + 1, startCnt);
    {txPktDone, txPktPending, txPktLoaded, txRetry} = 4'b1000;
    cyc(1);
    {txPktDone, txFifoBytes} = 0;
    cyc(1);
  endtask
  task pkt(input logic tag);
    logic [31:0] d;
    logic st, sy;
    st = vidM[0] && !keepRxHeader;
    sy = vidM[1] && st && bufferFillMode && branchCtl == 2'h1;
    for (int i = 0; i < 4; i++)
    begin
      d = $random(seed);
      if (i == 2 && tag) d = {8'h1F, d[23:20], 4'h7, d[15:0]};
      else d[31:24] = 8'h00;
      {rxQuadValid, rxQuadFirst, rxQuadData} = {1'b1, i == 0, d};
      if (tag && i == 2 && !waitM && !atFrameBoundary && sy) jmpE++;
      if ((!waitM || (tag && i == 2)) && !(st && i < 2)) expQ.push_back(d);
      if (tag && i == 2) waitM = 0;
      cyc(1);
    end
    rxQuadValid = 0;
    cyc(3);
    chk32("stored count", expQ.size(), gotQ.size());
    while (expQ.size() > 0 && gotQ.size() > 0)
      chk32("stored", expQ.pop_front(), gotQ.pop_front());
    expQ.delete();
    gotQ.delete();
    chk32("jumps", jmpE, jmpCnt);
    chk1("waiting", waitM[0], rxWaitingFrame);
  endtask
  //****************************************
  // Main sequence and watchdog
  //****************************************
  initial
  begin
    cyc(8);
    rst_b = 1;
    cyc(1);
    check_all();
    $display("Test reset done");
    for (int j = 0; j < 12; j++)
    begin
      k = $unsigned($random(seed)) % 5;
      wr(k == 4, tbl[k], $random(seed) & 32'hFFFFBFFF);
      check_all();
    end
    wr(0, `LINK_SET_OFS, 32'h00008000);
    check_all();
    wr(0, `LINK_CLR_OFS, 32'h00008000);
    wr(0, 12'h100, 32'hFFFFFFFF);
    rd(0, 12'h100, 0);
    rd(1, 12'h010, 0);
    check_all();
    $display("Test registers done");
    for (int c = 0; c < 4; c++)
    begin
      wr(1, `LINK_CFG_OFS, c << `THR_LSB);
      if (c == 0) tx(12'h7FF, 0, 1, 0);
      else tx(tbl2(c) - 1, tbl2(c), 0, 0);
    end
    tx(12'h7FF, 0, 1, 1);
    wr(1, `LINK_CFG_OFS, 32'h00001000);
    {txPktPending, txFifoBytes} = {1'b1, `THR_1K7};
    cyc(3);
    txFifoEmpty = 1;
    cyc(3);
    chk32("underrun", 1, errCnt);
    chk1("store fwd", 1'b1, storeFwdActive);
    {txFifoEmpty, txPktPending, txFifoBytes} = 0;
    cyc(2);
    tx(12'h7FF, 0, 1, 0);
    $display("Test transmit done");
    // Random register traffic may have left sync armed; start clean
    wr(0, `VID_CLR_OFS, 3);
    wr(0, `VID_SET_OFS, 1);
    pkt(0);
    keepRxHeader = 1;
    pkt(0);
    keepRxHeader = 0;
    wr(0, `VID_CLR_OFS, 1);
    wr(0, `VID_SET_OFS, 2);
    pkt(0);
    wr(0, `VID_SET_OFS, 1);
    waitM = 1;
    pkt(0);
    pkt(1);
    atFrameBoundary = 0;
    pkt(1);
    $display("Test receive done");
    wr(0, `LINK_SET_OFS, 32'h0000B000);
    powerRst_b = 0;
    cyc(2);
    powerRst_b = 1;
    {linkM, vidM, waitM} = 0;
    cyc(1);
    check_all();
    chk1("store fwd reset", 1'b0, storeFwdActive);
    $display("Test power reset done");
    complete_run();
  end
  function automatic logic [11:0] tbl2(input int c);
    return c == 1 ? `THR_1K7 : c == 2 ? `THR_1K : `THR_512;
  endfunction
  initial
  begin
    repeat (20000) @(posedge clock);
    errors++;
    complete_run();
  end
endmodule // link_extension_control_regs_tb_top
